//--- src/fcs_channel_status.sv
// Per-channel status bank: alarm end events, G.832 maintenance fields,
// transmit and receive data link FIFOs, behind an Avalon-MM slave.
// Line-side inputs come from framer logic on clk_sys; no synchronisers.
module fcs_channel_status
  import fcs_pkg::*;
#(
  parameter int TX_DEPTH = FCS_TX_DEPTH,
  parameter int RX_DEPTH = FCS_RX_DEPTH,
  parameter int BLOCK_MAX = FCS_BLOCK_MAX
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mode_e3,
  input wire logic mode_g832,
  input wire logic mode_cbit,
  input wire logic los_active,
  input wire logic idle_active,
  input wire logic rai_active,
  input wire logic ais_active,
  input wire logic oof_active,
  input wire logic ma_byte_valid,
  input wire logic [7:0] ma_byte,
  input wire logic feac_word_start,
  input wire logic feac_word_load,
  input wire logic tx_byte_req,
  input wire logic tx_msg_done,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  input wire logic rx_data_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_msg_end,
  input wire logic rx_abort,
  input wire logic rx_bits_odd,
  input wire logic rx_fcs_bad
);

  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam logic [TAW:0] TXD_L = (TAW+1)'(TX_DEPTH);
  localparam logic [RAW:0] RXD_L = (RAW+1)'(RX_DEPTH);
  localparam logic [6:0] BLK_MAX_L = 7'(BLOCK_MAX);

  typedef struct packed {
    logic [4:0] alm_end;
    logic [4:0] alm_prev;
    logic [5:0] maint;
    logic [3:0] ssm;
    logic [4:0] alm_en;
    logic ssm_en;
    logic feac_rep;
    logic [7:0] tx_thr;
    logic [7:0] rx_thr;
    logic feac_rdy;
    logic [3:0] feac_cnt;
    logic [TX_DEPTH-1:0][7:0] tx_mem;
    logic [TAW-1:0] tx_wp;
    logic [TAW-1:0] tx_rp;
    logic [TAW:0] tx_cnt;
    logic tx_msg;
    logic tx_ur;
    logic tx_empty;
    logic [7:0] tx_out;
    logic tx_out_v;
    logic [RX_DEPTH-1:0][9:0] rx_mem;
    logic [RAW-1:0] rx_wp;
    logic [RAW-1:0] rx_rp;
    logic [RAW:0] rx_cnt;
    logic [RAW:0] blocks;
    logic [RAW-1:0] slot;
    logic [6:0] blk_len;
    logic [6:0] rem;
    logic in_blk;
    logic drop;
    logic rx_ovr;
    logic rx_msg;
    logic rx_nf;
    logic av_wait;
    logic av_pop;
    logic [7:0] av_rdata;
  } fcs_state_t;

  fcs_state_t s_reg;
  fcs_state_t s_next;

  logic rd_acc;
  logic wr_acc;
  logic [9:0] rx_head;
  logic [RAW:0] rx_free;
  logic [4:0] alm_now;
  logic [7:0] tx_stat;
  logic [7:0] rx_stat;

  assign rd_acc = avs_read & ~s_reg.av_wait;
  assign wr_acc = avs_write & ~s_reg.av_wait;
  assign rx_head = s_reg.rx_mem[s_reg.rx_rp];
  assign rx_free = RXD_L - s_reg.rx_cnt;
  assign alm_now = {los_active, idle_active & ~mode_e3, rai_active,
                    ais_active, oof_active};
  assign tx_stat = {2'b00, s_reg.feac_rdy,
                    s_reg.tx_cnt == TXD_L,
                    s_reg.tx_msg, s_reg.tx_ur,
                    s_reg.tx_cnt <= {1'b0, s_reg.tx_thr},
                    s_reg.tx_empty};
  // Type and kind of the head entry mean nothing without a block
  assign rx_stat = {2'b00, rx_head[8], s_reg.rx_ovr, s_reg.rx_msg,
                    s_reg.rx_nf, s_reg.blocks != '0,
                    rx_head[9]};

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.tx_out_v = 1'b0;

    // Bus slave: capture on the first sampled edge, act on acceptance
    if (!s_reg.av_wait) begin
      s_next.av_wait = 1'b1;
      s_next.av_pop = 1'b0;
    end else if (avs_read || avs_write) begin
      s_next.av_wait = 1'b0;
      s_next.av_rdata = 8'h00;
      s_next.av_pop = 1'b0;
      if (avs_read) begin
        unique case (avs_address)
          FCS_ADR_ALARM_END: s_next.av_rdata = {3'b000, s_reg.alm_end};
          FCS_ADR_MAINT: s_next.av_rdata = {2'b00, s_reg.maint[5:1],
            s_reg.maint[0] & ~s_reg.ssm_en};
          FCS_ADR_SSM: s_next.av_rdata = {4'h0, s_reg.ssm};
          FCS_ADR_TX_STAT: s_next.av_rdata = tx_stat;
          FCS_ADR_RX_STAT: s_next.av_rdata = rx_stat;
          FCS_ADR_RX_PORT: begin
            if (s_reg.blocks != '0) begin
              s_next.av_rdata = rx_head[7:0];
              s_next.av_pop = 1'b1;
            end
          end
          FCS_ADR_CTRL: s_next.av_rdata = {1'b0, s_reg.feac_rep,
                                           s_reg.ssm_en, s_reg.alm_en};
          FCS_ADR_THR: s_next.av_rdata = s_reg.tx_thr;
          default: s_next.av_rdata = 8'h00;
        endcase
      end
    end

    // Alarm end events; only the bits already shown are cleared, and
    // a new event in the clearing cycle wins
    s_next.alm_prev = alm_now;
    if (rd_acc && avs_address == FCS_ADR_ALARM_END) begin
      s_next.alm_end = s_reg.alm_end & ~s_reg.av_rdata[4:0];
    end
    if (wr_acc && avs_address == FCS_ADR_CTRL) begin
      s_next.alm_end = s_next.alm_end & ~avs_writedata[4:0];
      s_next.alm_en = avs_writedata[4:0];
      s_next.ssm_en = avs_writedata[FCS_CTRL_SSM_EN];
      s_next.feac_rep = avs_writedata[FCS_CTRL_FEAC_REP];
    end
    if (wr_acc && avs_address == FCS_ADR_THR) begin
      s_next.tx_thr = avs_writedata[7:0];
      s_next.rx_thr = avs_writedata[FCS_THR_RX_LSB +: 8];
    end
    // Falling alarm level marks its end; idle is masked in E3
    s_next.alm_end = s_next.alm_end | (s_reg.alm_prev & ~alm_now);
    // A mode change must not fake an idle end in E3
    if (mode_e3) begin
      s_next.alm_end[3] = 1'b0;
    end

    // Maintenance byte fields: ma_byte[0] carries bit 1 of the byte
    if (mode_g832 && ma_byte_valid) begin
      s_next.maint = {ma_byte[2], ma_byte[3], ma_byte[4],
                      ma_byte[5], ma_byte[6],
                      ma_byte[7]};
      if (s_reg.ssm_en) begin
        s_next.ssm[2'd3 - {ma_byte[5], ma_byte[6]}] = ma_byte[7];
      end
    end

    // FEAC transmit readiness
    if (rd_acc && avs_address == FCS_ADR_TX_STAT) begin
      s_next.feac_rdy = s_reg.feac_rdy & ~s_reg.av_rdata[5];
      s_next.tx_msg = s_reg.tx_msg & ~s_reg.av_rdata[3];
      s_next.tx_ur = s_reg.tx_ur & ~s_reg.av_rdata[2];
    end
    if (feac_word_load) begin
      s_next.feac_cnt = 4'h0;
    end else if (mode_cbit && feac_word_start) begin
      if (!s_reg.feac_rep) begin
        s_next.feac_rdy = 1'b1;
      end else if (s_reg.feac_cnt != FCS_FEAC_REPEAT) begin
        s_next.feac_cnt = s_reg.feac_cnt + 4'h1;
        if (s_reg.feac_cnt == FCS_FEAC_REPEAT - 4'h1) begin
          s_next.feac_rdy = 1'b1;
        end
      end
    end
    if (tx_msg_done) begin
      s_next.tx_msg = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit data link FIFO; writes to a full FIFO are dropped
    if (wr_acc && avs_address == FCS_ADR_TX_WR && s_reg.tx_cnt != TXD_L) begin
      s_next.tx_mem[s_reg.tx_wp] = avs_writedata[7:0];
      s_next.tx_wp = s_reg.tx_wp + 1'b1;
      s_next.tx_cnt = s_next.tx_cnt + 1'b1;
      s_next.tx_empty = 1'b0;
    end
    if (tx_byte_req) begin
      if (s_reg.tx_cnt == '0) begin
        s_next.tx_ur = 1'b1;
      end else begin
        s_next.tx_out = s_reg.tx_mem[s_reg.tx_rp];
        s_next.tx_out_v = 1'b1;
        s_next.tx_rp = s_reg.tx_rp + 1'b1;
        s_next.tx_cnt = s_next.tx_cnt - 1'b1;
        if (s_reg.tx_cnt == 1) begin
          s_next.tx_empty = 1'b1;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive FIFO read side
    if (rd_acc && avs_address == FCS_ADR_RX_STAT) begin
      s_next.rx_msg = s_reg.rx_msg & ~s_reg.av_rdata[3];
    end
    if (rd_acc && s_reg.av_pop) begin
      s_next.rx_rp = s_reg.rx_rp + 1'b1;
      s_next.rx_cnt = s_next.rx_cnt - 1'b1;
      if (rx_head[9]) begin
        s_next.rem = rx_head[8] ? rx_head[6:0] : 7'd0;
        if (!rx_head[8] || rx_head[6:0] == 7'd0) begin
          s_next.blocks = s_next.blocks - 1'b1;
        end
      end else begin
        s_next.rem = s_reg.rem - 7'd1;
        if (s_reg.rem == 7'd1) begin
          s_next.blocks = s_next.blocks - 1'b1;
        end
      end
    end
    // Sticky until the reader has drained every complete block
    if (s_reg.blocks == '0) begin
      s_next.rx_ovr = 1'b0;
      s_next.rx_nf = 1'b0;
    end
    if (s_reg.rx_cnt >= {1'b0, s_reg.rx_thr}) begin
      s_next.rx_nf = 1'b1;
    end

    // Receive FIFO line side: a status slot is reserved ahead of each
    // block so the reader meets the status before the data it describes
    if (rx_data_valid && !s_reg.drop) begin
      if ((!s_reg.in_blk && rx_free < 2) || rx_free == '0) begin
        s_next.rx_ovr = 1'b1;
        s_next.drop = 1'b1;
        if (s_reg.in_blk) begin
          s_next.rx_mem[s_reg.slot] = {2'b10,
            fcs_err_code(1'b1, rx_abort, rx_bits_odd, rx_fcs_bad)};
          s_next.rx_wp = s_reg.slot + 1'b1;
          s_next.rx_cnt = s_next.rx_cnt - (RAW+1)'(s_reg.blk_len);
          s_next.blocks = s_next.blocks + 1'b1;
          s_next.in_blk = 1'b0;
          s_next.rx_msg = 1'b1;
        end
      end else if (!s_reg.in_blk) begin
        s_next.slot = s_reg.rx_wp;
        s_next.rx_mem[s_reg.rx_wp + 1'b1] = {2'b00, rx_data};
        s_next.rx_wp = s_reg.rx_wp + 2'd2;
        s_next.rx_cnt = s_next.rx_cnt + 2'd2;
        s_next.in_blk = 1'b1;
        s_next.blk_len = 7'd1;
      end else begin
        s_next.rx_mem[s_reg.rx_wp] = {2'b00, rx_data};
        s_next.rx_wp = s_reg.rx_wp + 1'b1;
        s_next.rx_cnt = s_next.rx_cnt + 1'b1;
        s_next.blk_len = s_reg.blk_len + 7'd1;
        if (s_reg.blk_len + 7'd1 == BLK_MAX_L) begin
          // Partial block: message continues in a new block
          s_next.rx_mem[s_reg.slot] = {3'b110, BLK_MAX_L};
          s_next.blocks = s_next.blocks + 1'b1;
          s_next.in_blk = 1'b0;
        end
      end
    end else if (rx_msg_end) begin
      s_next.drop = 1'b0;
      if (s_reg.in_blk || (!s_reg.drop && rx_free != '0)) begin
        if (!s_reg.in_blk) begin
          s_next.slot = s_reg.rx_wp;
          s_next.rx_wp = s_reg.rx_wp + 1'b1;
          s_next.rx_cnt = s_next.rx_cnt + 1'b1;
        end
        if (rx_abort || rx_bits_odd || rx_fcs_bad) begin
          s_next.rx_mem[s_next.slot] = {2'b10,
            fcs_err_code(1'b0, rx_abort, rx_bits_odd, rx_fcs_bad)};
          // Errored block carries no data: hand its bytes back
          if (s_reg.in_blk) begin
            s_next.rx_wp = s_reg.slot + 1'b1;
            s_next.rx_cnt = s_next.rx_cnt - (RAW+1)'(s_reg.blk_len);
          end
        end else begin
          s_next.rx_mem[s_next.slot] = {3'b111,
            s_reg.in_blk ? s_reg.blk_len : 7'd0};
        end
        s_next.blocks = s_next.blocks + 1'b1;
        s_next.in_blk = 1'b0;
        s_next.rx_msg = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.alm_prev <= 5'h00;
      s_reg.tx_thr <= FCS_TX_NE_THR_RST;
      s_reg.rx_thr <= FCS_RX_NF_THR_RST;
      s_reg.tx_empty <= 1'b1;
      s_reg.av_wait <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = {24'h000000, s_reg.av_rdata};
  assign avs_waitrequest = s_reg.av_wait;
  assign tx_byte = s_reg.tx_out;
  assign tx_byte_valid = s_reg.tx_out_v;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_los_end_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(los_active) |=> s_reg.alm_end[4])
    else $error("signal loss end not flagged");

  a_idle_e3_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_e3 |=> !s_reg.alm_end[3])
    else $error("idle end flag rose in E3 mode");

  a_ais_end_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(ais_active) |=> s_reg.alm_end[1])
    else $error("AIS end not flagged");

  a_oof_end_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(oof_active) |=> s_reg.alm_end[0])
    else $error("frame loss end not flagged");

  a_enable_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_acc && avs_address == FCS_ADR_CTRL && avs_writedata[0]
     && !$fell(oof_active)) |=> !s_reg.alm_end[0])
    else $error("enable write left event flag set");

  a_ssm_order: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode_g832 && ma_byte_valid && s_reg.ssm_en && ma_byte[6:5] == 2'b00)
    |=> s_reg.ssm[3] == $past(ma_byte[7]))
    else $error("sync message bit misplaced");

  a_underrun_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tx_byte_req && s_reg.tx_cnt == '0) |=> s_reg.tx_ur && !tx_byte_valid)
    else $error("underrun not flagged");

  a_empty_on_drain: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tx_byte_req && s_reg.tx_cnt == 1 && !wr_acc)
    |=> s_reg.tx_empty && tx_byte_valid
    ##1 (s_reg.tx_empty || s_reg.tx_cnt != '0))
    else $error("empty flag missing after last pop");

  a_rx_overrun: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rx_data_valid && !s_reg.drop && s_reg.rx_cnt == RXD_L)
    |=> s_reg.rx_ovr && s_reg.drop)
    else $error("receive overrun not flagged");

  a_blocks_need_data: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    s_reg.rx_cnt == '0 |-> s_reg.blocks == '0)
    else $error("blocks counted in empty FIFO");

  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((avs_read || avs_write) && s_reg.av_wait) |=> !avs_waitrequest
    ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

endmodule

//--- src/fcs_pkg.sv
// Constants shared by the framer channel status register bank.
// Assumes one channel, one clock, and an Avalon-MM master in front.
//
// Function
// - Signal-loss end sets flag; read clears it
// - Idle end flag in DS3 only; low in E3
// - Remote alarm and AIS end flags, read-cleared
// - Frame regained sets end flag; read clears
// - Writing event enable clears that event flag
// - Capture payload type bits 3-5, no interrupt
// - Capture payload dependent bits 6-7, no interrupt
// - Timing marker valid only with message mode off
// - Four-bit sync message ordered by multiframe indicator
// - FEAC transmit ready per start or tenth repeat
// - Transmit full flag while FIFO holds 128
// - Message sent flag on closing flag; read clears
// - Underrun on fetch from empty transmit FIFO
// - Near-empty while occupancy at or below threshold
// - Empty set on last pop, even if a write lands in that cycle; else cleared by write
// - Receive overrun on full; clears without blocks
// - Message flag on end-of-message status byte write
// - Near-full at threshold; clears without complete blocks
// - Complete blocks flag until last block drained
// - Flag shows whether next byte is status
// - Each port read pops one receive FIFO entry while a complete block is held
// - Good status: bit 7 complete, low seven length
// - Errored status: zero length, single error bit
// - Error priority overrun, abort, alignment, frame check
package fcs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [5:0] FCS_ADR_ALARM_END = 6'h00;
  localparam logic [5:0] FCS_ADR_MAINT = 6'h04;
  localparam logic [5:0] FCS_ADR_SSM = 6'h08;
  localparam logic [5:0] FCS_ADR_TX_STAT = 6'h0c;
  localparam logic [5:0] FCS_ADR_RX_STAT = 6'h10;
  localparam logic [5:0] FCS_ADR_RX_PORT = 6'h14;
  localparam logic [5:0] FCS_ADR_CTRL = 6'h18;
  localparam logic [5:0] FCS_ADR_THR = 6'h1c;
  localparam logic [5:0] FCS_ADR_TX_WR = 6'h20;

  ////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int FCS_CTRL_SSM_EN = 5;
  localparam int FCS_CTRL_FEAC_REP = 6;
  localparam int FCS_THR_RX_LSB = 8;
  localparam logic [7:0] FCS_TX_NE_THR_RST = 8'h10;
  localparam logic [7:0] FCS_RX_NF_THR_RST = 8'h60;
  localparam logic [3:0] FCS_FEAC_REPEAT = 4'ha;
  localparam logic [7:0] FCS_ERR_ABORT = 8'h08;
  localparam logic [7:0] FCS_ERR_OVR = 8'h04;
  localparam logic [7:0] FCS_ERR_ALIGN = 8'h02;
  localparam logic [7:0] FCS_ERR_FCS = 8'h01;
  localparam int FCS_TX_DEPTH = 128;
  localparam int FCS_RX_DEPTH = 128;
  localparam int FCS_BLOCK_MAX = 127;

  // Only the most urgent error survives into the status byte
  function automatic logic [7:0] fcs_err_code(input logic overrun_error_flag,
      input logic abort, input logic odd, input logic bad);
    if (overrun_error_flag) begin
      return FCS_ERR_OVR;
    end else if (abort) begin
      return FCS_ERR_ABORT;
    end else if (odd) begin
      return FCS_ERR_ALIGN;
    end else if (bad) begin
      return FCS_ERR_FCS;
    end
    return 8'h00;
  endfunction

endpackage

//--- dv/fcs_line_model.sv
// Line-side partner: framer receiver and transmitter strobes.
// Assumes the bench calls its tasks right after a clk_sys edge.
module fcs_line_model (
  input wire logic clk_sys,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  output logic [4:0] alarm_lvl,
  output logic ma_byte_valid,
  output logic [7:0] ma_byte,
  output logic feac_word_start,
  output logic feac_word_load,
  output logic tx_byte_req,
  output logic tx_msg_done,
  output logic rx_data_valid,
  output logic [7:0] rx_data,
  output logic rx_msg_end,
  output logic [2:0] rx_err
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    alarm_lvl = 5'h00;
    {ma_byte_valid, feac_word_start, feac_word_load} = 3'h0;
    {tx_byte_req, tx_msg_done, rx_data_valid, rx_msg_end} = 4'h0;
    ma_byte = 8'h00;
    rx_data = 8'h00;
    rx_err = 3'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // Alarm level high a few cycles; its falling edge is the end event
  task automatic alarm(input int i);
    @(posedge clk_sys);
    alarm_lvl[i] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    alarm_lvl[i] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // Stale bytes are inverted so nothing can latch a leftover value
  task automatic send_ma(input logic [7:0] x);
    @(posedge clk_sys);
    ma_byte <= x;
    ma_byte_valid <= 1'b1;
    @(posedge clk_sys);
    ma_byte_valid <= 1'b0;
    ma_byte <= ~x;
  endtask

  task automatic feac(input logic load);
    @(posedge clk_sys);
    feac_word_load <= load;
    feac_word_start <= !load;
    @(posedge clk_sys);
    feac_word_load <= 1'b0;
    feac_word_start <= 1'b0;
  endtask

  // Bit 0 of each byte is the first bit off the line
  task automatic send_data(input logic [7:0] x);
    @(posedge clk_sys);
    rx_data <= x;
    rx_data_valid <= 1'b1;
    @(posedge clk_sys);
    rx_data_valid <= 1'b0;
    rx_data <= ~x;
  endtask

  task automatic end_msg(input logic [2:0] x);
    @(posedge clk_sys);
    rx_err <= x;
    rx_msg_end <= 1'b1;
    @(posedge clk_sys);
    rx_msg_end <= 1'b0;
    rx_err <= ~x;
  endtask

  task automatic msg_done();
    @(posedge clk_sys);
    tx_msg_done <= 1'b1;
    @(posedge clk_sys);
    tx_msg_done <= 1'b0;
  endtask

  // Fetches at the bench's pace, so it can outrun the refill
  task automatic fetch(output logic ok, output logic [7:0] x);
    @(posedge clk_sys);
    tx_byte_req <= 1'b1;
    @(posedge clk_sys);
    tx_byte_req <= 1'b0;
    @(posedge clk_sys);
    ok = tx_byte_valid;
    x = tx_byte;
  endtask
endmodule

//--- dv/test_framer_channel_status_regs.sv
// Self-checking bench for the channel status bank.
// Assumes fcs_pkg, fcs_channel_status and fcs_line_model are compiled.
module test_framer_channel_status_regs;
  import fcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin \
  n_mismatch++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, x); end end

  logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest, v;
  logic mode_e3, mode_g832, mode_cbit;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [4:0] alarm_lvl;
  logic ma_byte_valid, feac_word_start, feac_word_load;
  logic tx_byte_req, tx_msg_done, tx_byte_valid;
  logic rx_data_valid, rx_msg_end;
  logic [2:0] rx_err;
  logic [2:0] errs [4];
  logic [7:0] ma_byte, tx_byte, rx_data, rd, b, e, tm;
  logic [7:0] q [$];
  int n_mismatch, cmp_count, cycles, n;

  fcs_channel_status i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mode_e3(mode_e3), .mode_g832(mode_g832), .mode_cbit(mode_cbit),
    .los_active(alarm_lvl[4]), .idle_active(alarm_lvl[3]),
    .rai_active(alarm_lvl[2]), .ais_active(alarm_lvl[1]),
    .oof_active(alarm_lvl[0]), .ma_byte_valid(ma_byte_valid),
    .ma_byte(ma_byte), .feac_word_start(feac_word_start),
    .feac_word_load(feac_word_load), .tx_byte_req(tx_byte_req),
    .tx_msg_done(tx_msg_done), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .rx_data_valid(rx_data_valid),
    .rx_data(rx_data), .rx_msg_end(rx_msg_end), .rx_abort(rx_err[2]),
    .rx_bits_odd(rx_err[1]), .rx_fcs_bad(rx_err[0]));

  fcs_line_model i_line (.clk_sys(clk_sys), .tx_byte_valid(tx_byte_valid),
    .tx_byte(tx_byte), .alarm_lvl(alarm_lvl),
    .ma_byte_valid(ma_byte_valid), .ma_byte(ma_byte),
    .feac_word_start(feac_word_start), .feac_word_load(feac_word_load),
    .tx_byte_req(tx_byte_req), .tx_msg_done(tx_msg_done),
    .rx_data_valid(rx_data_valid), .rx_data(rx_data),
    .rx_msg_end(rx_msg_end), .rx_err(rx_err));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  // Most urgent error only: abort, then alignment, then frame check
  function automatic logic [7:0] err_code(input logic [2:0] x);
    if (x[2]) return FCS_ERR_ABORT;
    if (x[1]) return FCS_ERR_ALIGN;
    return x[0] ? FCS_ERR_FCS : 8'h00;
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
  endtask

  // Request held until waitrequest is sampled low at an edge
  task automatic bus_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask

  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] m,
      input logic [7:0] x);
    bus_rd(a, rd);
    `CHK(rd & m, x)
  endtask

  task automatic rx_msg(input int len, input logic [2:0] x);
    q.delete();
    repeat (len) begin
      b = rnd();
      q.push_back(b);
      i_line.send_data(b);
    end
    i_line.end_msg(x);
  endtask

  task automatic drain(input int len);
    repeat (len) begin
      e = q.pop_front();
      rd_chk(FCS_ADR_RX_PORT, 8'hff, e);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, mode_e3, mode_g832, mode_cbit} = 5'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    seed = 32'h0a14ac9d;
    errs = '{3'b000, 3'b111, 3'b011, 3'b001};
    do_reset();
    rd_chk(FCS_ADR_TX_STAT, 8'hff, 8'h03);
    rd_chk(6'h3c, 8'hff, 8'h00);
    for (int i = 0; i < 5; i++) begin
      i_line.alarm(i);
      rd_chk(FCS_ADR_ALARM_END, 8'hff, 8'h01 << i);
      rd_chk(FCS_ADR_ALARM_END, 8'hff, 8'h00);
    end
    mode_e3 <= 1'b1;
    i_line.alarm(3);
    rd_chk(FCS_ADR_ALARM_END, 8'hff, 8'h00);
    mode_e3 <= 1'b0;
    i_line.alarm(0);
    bus_wr(FCS_ADR_CTRL, 16'h0001);
    rd_chk(FCS_ADR_ALARM_END, 8'hff, 8'h00);
    mode_g832 <= 1'b1;
    repeat (6) begin
      b = rnd();
      i_line.send_ma(b);
      tm = {2'b0, b[2], b[3], b[4], b[5], b[6], b[7]};
      rd_chk(FCS_ADR_MAINT, 8'hff, tm);
    end
    bus_wr(FCS_ADR_CTRL, 16'h0020);
    tm = rnd();
    for (int m = 0; m < 4; m++) i_line.send_ma({tm[m], m[0], m[1], 5'(rnd())});
    rd_chk(FCS_ADR_SSM, 8'hff, {4'h0, tm[0], tm[1], tm[2], tm[3]});
    rd_chk(FCS_ADR_MAINT, 8'h01, 8'h00);
    b = rnd();
    mode_cbit <= b[0];
    i_line.feac(1'b0);
    rd_chk(FCS_ADR_TX_STAT, 8'h20, {2'b00, b[0], 5'h00});
    mode_cbit <= 1'b1;
    bus_wr(FCS_ADR_CTRL, 16'h0000);
    i_line.feac(1'b0);
    rd_chk(FCS_ADR_TX_STAT, 8'h20, 8'h20);
    rd_chk(FCS_ADR_TX_STAT, 8'h20, 8'h00);
    bus_wr(FCS_ADR_CTRL, 16'h0040);
    rd_chk(FCS_ADR_CTRL, 8'hff, 8'h40);
    i_line.feac(1'b1);
    repeat (9) i_line.feac(1'b0);
    rd_chk(FCS_ADR_TX_STAT, 8'h20, 8'h00);
    i_line.feac(1'b0);
    rd_chk(FCS_ADR_TX_STAT, 8'h20, 8'h20);
    q.delete();
    repeat (128) begin
      b = rnd();
      q.push_back(b);
      bus_wr(FCS_ADR_TX_WR, {8'h00, b});
    end
    rd_chk(FCS_ADR_TX_STAT, 8'h1f, 8'h10);
    bus_wr(FCS_ADR_TX_WR, 16'h005a);
    for (int i = 0; i < 128; i++) begin
      i_line.fetch(v, b);
      e = q.pop_front();
      `CHK(v, 1'b1)
      `CHK(b, e)
      if (i == 0) rd_chk(FCS_ADR_TX_STAT, 8'h10, 8'h00);
      if (i == 110) rd_chk(FCS_ADR_TX_STAT, 8'h02, 8'h00);
      if (i == 111) rd_chk(FCS_ADR_TX_STAT, 8'h02, 8'h02);
    end
    rd_chk(FCS_ADR_TX_STAT, 8'h07, 8'h03);
    i_line.fetch(v, b);
    `CHK(v, 1'b0)
    rd_chk(FCS_ADR_TX_STAT, 8'h07, 8'h07);
    rd_chk(FCS_ADR_TX_STAT, 8'h04, 8'h00);
    i_line.msg_done();
    rd_chk(FCS_ADR_TX_STAT, 8'h08, 8'h08);
    rd_chk(FCS_ADR_TX_STAT, 8'h08, 8'h00);
    bus_wr(FCS_ADR_TX_WR, 16'h0033);
    rd_chk(FCS_ADR_TX_STAT, 8'h01, 8'h00);
    for (int k = 0; k < 4; k++) begin
      do_reset();
      n = 1 + int'(rnd() % 8);
      rx_msg(n, errs[k]);
      if (errs[k] == 3'b000) begin
        rd_chk(FCS_ADR_RX_STAT, 8'h3f, 8'h2b);
        rd_chk(FCS_ADR_RX_PORT, 8'hff, 8'h80 | 8'(n));
        rd_chk(FCS_ADR_RX_STAT, 8'h03, 8'h02);
        drain(n);
        rd_chk(FCS_ADR_RX_STAT, 8'h0a, 8'h00);
      end else begin
        rd_chk(FCS_ADR_RX_STAT, 8'h3c, 8'h08);
        rd_chk(FCS_ADR_RX_PORT, 8'hff, err_code(errs[k]));
        rx_msg(1, 3'b000);
        rd_chk(FCS_ADR_RX_PORT, 8'hff, 8'h81);
      end
    end
    do_reset();
    rx_msg(130, 3'b000);
    rd_chk(FCS_ADR_RX_STAT, 8'h16, 8'h16);
    rd_chk(FCS_ADR_RX_PORT, 8'hff, 8'h7f);
    drain(127);
    for (int len = 3; len < 5; len++) begin
      do_reset();
      bus_wr(FCS_ADR_THR, 16'h0510);
      rd_chk(FCS_ADR_THR, 8'hff, 8'h10);
      rx_msg(len, 3'b000);
      rd_chk(FCS_ADR_RX_STAT, 8'h04, len == 4 ? 8'h04 : 8'h00);
      rd_chk(FCS_ADR_RX_PORT, 8'hff, 8'h80 | 8'(len));
      drain(len);
      rd_chk(FCS_ADR_RX_STAT, 8'h06, 8'h00);
    end
    report_and_stop();
  end
endmodule
